//--- dis_interrupt_status.sv
// interrupt status and control register with active-low interrupt pin
//
// Overview of operation
// - 16-bit register at address 0x09; bits 11:10 and 7:3 are status.
// - bits 1:0 are mask bits, host writable and readable.
// - status bits change only by internal logic, except bit 11, cleared by a host write to bit 12.
// - writing 1 to bit 12 clears the latched sync-lock-lost flag.
// - bit 12 stays as written; host must write it back to 0.
// - bit 11 sets on sync loss and stays until cleared via bit 12.
// - bit 10 shows live sync state, high while synchronized.
// - bit 7 resets to 0, sets on data port timing error.
// - bit 6 resets to 0, sets on sync receiver timing error.
// - bit 5 gives data error type: 1 setup, 0 hold.
// - bit 4 gives sync error type: 1 setup, 0 hold.
// - bit 3 shows PLL lock, 0 by default.
// - bit 1 enables data errors onto flag and pin; default masked.
// - bit 0 enables sync errors onto flag and pin; default masked.
// - interrupt request output is active low.
`timescale 1ns/1ps
module dis_interrupt_status
    import dis_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rstn,
    input  wire logic          clkEn,
    input  wire logic [4:0]    regAddr,
    input  wire logic          regWrite,
    input  wire logic [15:0]   regWdata,
    output logic      [15:0]   regRdata,
    input  wire logic          syncLocked,
    input  wire logic          pllLocked,
    input  wire dis_check_type dataCheck,
    input  wire dis_check_type syncCheck,
    output logic               irqN
);
    logic       clearLock_r, clearLock_nxt;
    logic       lockLost_r, lockLost_nxt;
    logic       dataErr_r, dataErr_nxt;
    logic       syncErr_r, syncErr_nxt;
    logic       dataType_r, dataType_nxt;
    logic       syncType_r, syncType_nxt;
    logic [1:0] mask_r, mask_nxt;
    logic       hit;

    // one decode shared by the write strobe and the read mux
    function automatic logic addrHit(input logic [4:0] addr);
        return addr == INT_REG_ADDR;
    endfunction

    assign hit = regWrite && addrHit(regAddr);

    always_comb begin
        clearLock_nxt = clearLock_r;
        mask_nxt      = mask_r;
        if (hit) begin
            clearLock_nxt = regWdata[BIT_CLEAR_LOCK];
            mask_nxt      = regWdata[1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            clearLock_r <= REG_RESET[BIT_CLEAR_LOCK];
            mask_r      <= REG_RESET[1:0];
        end else if (clkEn) begin
            clearLock_r <= clearLock_nxt;
            mask_r      <= mask_nxt;
        end
    end

    // loss wins over a clear in the same cycle
    always_comb begin
        lockLost_nxt = lockLost_r;
        if (hit && regWdata[BIT_CLEAR_LOCK])
            lockLost_nxt = 1'b0;
        if (!syncLocked)
            lockLost_nxt = 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            lockLost_r <= REG_RESET[BIT_LOCK_LOST];
        end else if (clkEn) begin
            lockLost_r <= lockLost_nxt;
        end
    end

    // masked errors are dropped, not remembered for later enable
    // first error wins; later reports keep the recorded type
    always_comb begin
        dataErr_nxt  = dataErr_r;
        dataType_nxt = dataType_r;
        if (dataCheck.err && mask_r[BIT_DATA_EN] && !dataErr_r) begin
            dataErr_nxt  = 1'b1;
            dataType_nxt = dataCheck.isSetup;
        end
        syncErr_nxt  = syncErr_r;
        syncType_nxt = syncType_r;
        if (syncCheck.err && mask_r[BIT_SYNC_EN] && !syncErr_r) begin
            syncErr_nxt  = 1'b1;
            syncType_nxt = syncCheck.isSetup;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dataErr_r   <= REG_RESET[BIT_DATA_ERR];
            syncErr_r   <= REG_RESET[BIT_SYNC_ERR];
            dataType_r  <= REG_RESET[BIT_DATA_TYPE];
            syncType_r  <= REG_RESET[BIT_SYNC_TYPE];
        end else if (clkEn) begin
            dataErr_r   <= dataErr_nxt;
            syncErr_r   <= syncErr_nxt;
            dataType_r  <= dataType_nxt;
            syncType_r  <= syncType_nxt;
        end
    end

    // read path is combinational so live status is never a cycle stale
    always_comb begin
        regRdata = 16'h0000;
        if (addrHit(regAddr)) begin
            regRdata[BIT_CLEAR_LOCK] = clearLock_r;
            regRdata[BIT_LOCK_LOST]  = lockLost_r;
            regRdata[BIT_LOCK]       = syncLocked;
            regRdata[BIT_DATA_ERR]   = dataErr_r;
            regRdata[BIT_SYNC_ERR]   = syncErr_r;
            regRdata[BIT_DATA_TYPE]  = dataType_r;
            regRdata[BIT_SYNC_TYPE]  = syncType_r;
            regRdata[BIT_PLL_LOCK]   = pllLocked;
            regRdata[1:0]            = mask_r;
        end
    end

    // lock loss is status only; it never pulls the pin
    assign irqN = !((dataErr_r && mask_r[BIT_DATA_EN]) ||
                    (syncErr_r && mask_r[BIT_SYNC_EN]));

    lost_sets_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clkEn && !syncLocked |=> lockLost_r)
        else $error("lock lost flag not set");
    lost_clears_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clkEn && hit && regWdata[BIT_CLEAR_LOCK] && syncLocked |=> !lockLost_r)
        else $error("lock lost flag not cleared");
    lost_holds_a: assert property (@(posedge core_clk) disable iff (!rstn)
        lockLost_r && !(hit && regWdata[BIT_CLEAR_LOCK]) |=> lockLost_r)
        else $error("lock lost flag dropped");
    clr_sticks_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clearLock_r && !hit |=> clearLock_r)
        else $error("clear bit reset itself");
    data_err_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clkEn && dataCheck.err && mask_r[1] && !dataErr_r
        |=> dataErr_r && dataType_r == $past(dataCheck.isSetup))
        else $error("data error not captured");
    sync_err_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clkEn && syncCheck.err && mask_r[0] && !syncErr_r
        |=> syncErr_r && syncType_r == $past(syncCheck.isSetup))
        else $error("sync error not captured");
    err_holds_a: assert property (@(posedge core_clk) disable iff (!rstn)
        dataErr_r |=> dataErr_r && $stable(dataType_r))
        else $error("data error flag changed");
    irq_pin_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (dataErr_r && mask_r[1]) |-> !irqN)
        else $error("irq not asserted");
    mask_rw_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clkEn && hit |=> regAddr != INT_REG_ADDR ||
        regRdata[1:0] == $past(regWdata[1:0]))
        else $error("mask readback wrong");


    irq_sync_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (syncErr_r && mask_r[BIT_SYNC_EN]) |-> !irqN)
        else $error("irq not asserted for sync error");
    irq_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !(dataErr_r && mask_r[BIT_DATA_EN]) &&
        !(syncErr_r && mask_r[BIT_SYNC_EN]) |-> irqN)
        else $error("irq active with no enabled flag");
    data_mask_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clkEn && !mask_r[BIT_DATA_EN] && !dataErr_r
        |=> !dataErr_r)
        else $error("masked data error captured");
    sync_mask_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clkEn && !mask_r[BIT_SYNC_EN] && !syncErr_r
        |=> !syncErr_r)
        else $error("masked sync error captured");
    sync_holds_a: assert property (@(posedge core_clk) disable iff (!rstn)
        syncErr_r |=> syncErr_r && $stable(syncType_r))
        else $error("sync error flag changed");
    clr_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clkEn && hit
        |=> clearLock_r == $past(regWdata[BIT_CLEAR_LOCK]))
        else $error("clear bit not as written");

    reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
        regRdata[15:13] == 3'h0 && regRdata[9:8] == 2'h0 && !regRdata[2])
        else $error("reserved bits not zero");
    unmapped_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !addrHit(regAddr) |-> regRdata == 16'h0000)
        else $error("unmapped address read nonzero");
    live_lock_a: assert property (@(posedge core_clk) disable iff (!rstn)
        addrHit(regAddr) |-> regRdata[BIT_LOCK] == syncLocked)
        else $error("sync lock status wrong");
    pll_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
        addrHit(regAddr) |-> regRdata[BIT_PLL_LOCK] == pllLocked)
        else $error("pll lock status wrong");
    status_ro_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clkEn && hit && syncLocked && !regWdata[BIT_CLEAR_LOCK] &&
        !dataCheck.err && !syncCheck.err
        |=> $stable(lockLost_r) && $stable(dataErr_r) && $stable(syncErr_r))
        else $error("status bit changed by host write");
    reset_clear_a: assert property (@(posedge core_clk)
        !rstn |=> !dataErr_r && !syncErr_r && !lockLost_r && !clearLock_r &&
        mask_r == 2'h0 && irqN)
        else $error("state not cleared by reset");
    state_freeze_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !clkEn |=> $stable(mask_r) && $stable(clearLock_r) &&
        $stable(lockLost_r) && $stable(dataErr_r) && $stable(syncErr_r))
        else $error("state moved while clock enable low");

    lost_cv: cover property (@(posedge core_clk) lockLost_r ##1 !lockLost_r);
    irq_cv: cover property (@(posedge core_clk) $fell(irqN));
    sync_cv: cover property (@(posedge core_clk) $rose(syncErr_r));
    data_cv: cover property (@(posedge core_clk) $rose(dataErr_r));
    wins_cv: cover property (@(posedge core_clk)
        clkEn && !syncLocked && hit && regWdata[BIT_CLEAR_LOCK]);
endmodule // dis_interrupt_status

//--- dis_pkg.sv
// constants and carrier types for the interrupt status/control register
package dis_pkg;
    localparam logic [4:0]  INT_REG_ADDR   = 5'h09;
    localparam int          REG_WIDTH      = 16;
    localparam int          BIT_CLEAR_LOCK = 12;
    localparam int          BIT_LOCK_LOST  = 11;
    localparam int          BIT_LOCK       = 10;
    localparam int          BIT_DATA_ERR   = 7;
    localparam int          BIT_SYNC_ERR   = 6;
    localparam int          BIT_DATA_TYPE  = 5;
    localparam int          BIT_SYNC_TYPE  = 4;
    localparam int          BIT_PLL_LOCK   = 3;
    localparam int          BIT_DATA_EN    = 1;
    localparam int          BIT_SYNC_EN    = 0;
    localparam logic [15:0] REG_RESET      = 16'h0000;

    // one timing checker report: error pulse plus kind (1 = setup)
    typedef struct packed {
        logic err;
        logic isSetup;
    } dis_check_type;
endpackage

//--- dis_event_src.sv
// far-side model: lock levels and timing checker reports
`timescale 1ns/1ps
module dis_event_src
    import dis_pkg::*;
(
    input  wire logic     core_clk,
    output logic          syncLocked,
    output logic          pllLocked,
    output dis_check_type dataCheck,
    output dis_check_type syncCheck
);
    initial begin
        syncLocked = 1'b1;
        pllLocked  = 1'b0;
        dataCheck  = '0;
        syncCheck  = '0;
    end
    // one-cycle report, launched off the sampling edge
    task automatic pulse(input logic isData, input logic setup);
        @(negedge core_clk);
        if (isData) dataCheck = '{1'b1, setup};
        else syncCheck = '{1'b1, setup};
        @(negedge core_clk);
        dataCheck = '0;
        syncCheck = '0;
    endtask
endmodule // dis_event_src

//--- dac_interrupt_status_control_bench.sv
// self-checking bench for the interrupt status register
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module dac_interrupt_status_control_bench;
    import dis_pkg::*;
    logic          core_clk = 1'b0, rstn = 1'b0, clkEn = 1'b1;
    logic          regWrite = 1'b0, syncLocked, pllLocked, irqN;
    logic [4:0]    regAddr  = INT_REG_ADDR;
    logic [15:0]   regWdata = 16'h0000, regRdata;
    dis_check_type dataCheck, syncCheck;
    int            bad_count = 0, compares = 0;
    dis_interrupt_status dut_u (.core_clk(core_clk), .rstn(rstn),
        .clkEn(clkEn), .regAddr(regAddr), .regWrite(regWrite),
        .regWdata(regWdata), .regRdata(regRdata), .syncLocked(syncLocked),
        .pllLocked(pllLocked), .dataCheck(dataCheck),
        .syncCheck(syncCheck), .irqN(irqN));
    dis_event_src evt_u (.core_clk(core_clk), .syncLocked(syncLocked),
        .pllLocked(pllLocked), .dataCheck(dataCheck),
        .syncCheck(syncCheck));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge core_clk);
        regAddr  = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge core_clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [15:0] e, input logic q);
        #1;
        `CHK("regRdata", e, regRdata)
        `CHK("irqN", q, irqN)
    endtask
    task automatic final_report;
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #5000;
        bad_count++;
        final_report();
    end
    initial begin
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        rd(16'h0400, 1'b1);
        wr(INT_REG_ADDR, 16'hffff);
        rd(16'h1403, 1'b1);
        @(negedge core_clk);
        clkEn = 1'b0;
        wr(INT_REG_ADDR, 16'h0000);
        clkEn = 1'b1;
        rd(16'h1403, 1'b1);
        wr(INT_REG_ADDR, 16'h0000);
        evt_u.pllLocked = 1'b1;
        evt_u.pulse(1'b1, 1'b1);
        evt_u.pulse(1'b0, 1'b1);
        rd(16'h0408, 1'b1);
        wr(INT_REG_ADDR, 16'h0003);
        evt_u.pulse(1'b1, 1'b1);
        evt_u.pulse(1'b0, 1'b0);
        evt_u.pulse(1'b1, 1'b0);
        rd(16'h04eb, 1'b0);
        wr(5'h0a, 16'hffff);
        rd(16'h0000, 1'b0);
        @(negedge core_clk);
        regAddr = INT_REG_ADDR;
        rd(16'h04eb, 1'b0);
        wr(INT_REG_ADDR, 16'h0001);
        rd(16'h04e9, 1'b0);
        wr(INT_REG_ADDR, 16'h0000);
        rd(16'h04e8, 1'b1);
        @(negedge core_clk);
        evt_u.syncLocked = 1'b0;
        @(negedge core_clk);
        rd(16'h08e8, 1'b1);
        wr(INT_REG_ADDR, 16'h1000);
        rd(16'h18e8, 1'b1);
        wr(INT_REG_ADDR, 16'h0000);
        evt_u.syncLocked = 1'b1;
        @(negedge core_clk);
        rd(16'h0ce8, 1'b1);
        wr(INT_REG_ADDR, 16'h1000);
        rd(16'h14e8, 1'b1);
        wr(INT_REG_ADDR, 16'h0000);
        rd(16'h04e8, 1'b1);
        @(negedge core_clk);
        rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        rd(16'h0408, 1'b1);
        final_report();
    end
endmodule // dac_interrupt_status_control_bench
